/* rtl/poc_top.sv */
// Purpose: Phase overcurrent element with direction, restraint, inrush doubling, blocking
// Assumes: Measurements arrive on the system clock; blocking input is an async pin
// Notes:   All timers advance on a common 10 ms tick
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "poc_consts.svh"

// Notes on behaviour
// - Trip after current above pickup for delay
// - Measured current is largest phase magnitude
// - Disabled direction: magnitude only starts element
// - Supervision: voltage, current, angle within ninety
// - Vector mode: projected component at least pickup
// - Vector mode works down to low voltage
// - Reference angle 0 to 359, default 359
// - Restraint uses smallest scaled phase voltage ratio
// - Restraint multiplier 0.2, linear, then 1
// - Instantaneous sets above pickup, clears below 0.95
// - Blocking output routed to one selected relay
// - Blocking output dropped after reset delay
// - Blocking input inhibits delayed trip
// - Release off: block while input active
// - Release doubled: ignore input after twice delay
// - Fast rise to 1.5 rated doubles pickup
// - Doubling ends below 1.25 or timeout
// - Doubling timeout settable, rise window 60 ms
// - Pickup 0.1 to 40 rated, default 40
// - Element and options default off
// - Phase currents saturate at 40 rated
module poc_top #(
  parameter int TICK_CYCLES = `POC_TICK_MS * `POC_CLK_KHZ,
  parameter int RISE_TICKS  = `POC_RISE_WIN_MS / `POC_TICK_MS
) (
  input  wire logic                   CLK_SYS,
  input  wire logic                   SYS_RST,
  input  wire poc_pkg::poc_apb_req_type APB_REQ,
  output logic [31:0]                 PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire poc_pkg::poc_meas_type  MEAS,
  input  wire logic                   BLOCK_IN,
  output logic                        INST_START,
  output logic                        TRIP,
  output logic                        BLOCK_OUT,
  output logic [7:0]                  RELAY_OUT
);
  import poc_pkg::*;

  poc_state_type s;
  poc_state_type next_s;

  function automatic logic addr_ok(input logic [11:0] a);
    case (a)
      `POC_OFS_CTRL, `POC_OFS_PICKUP, `POC_OFS_ANGLE, `POC_OFS_TRIP,
      `POC_OFS_BODLY, `POC_OFS_DBLMAX, `POC_OFS_NOMV, `POC_OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    if (v < lo) clamp = lo;
    else if (v > hi) clamp = hi;
    else clamp = v;
  endfunction : clamp

  // Quarter-wave cosine in 10 degree steps, linear in between; Q12
  function automatic logic signed [13:0] cos_q12(input logic [9:0] d);
    logic [12:0] tab [0:9];
    logic [9:0]  r;
    logic [3:0]  i;
    logic [3:0]  f;
    logic [12:0] v;
    logic        neg;
    tab = '{13'h1000, 13'h0FC2, 13'h0F09, 13'h0DDB, 13'h0C42,
            13'h0A49, 13'h0800, 13'h0579, 13'h02C7, 13'h0000};
    neg = 1'b0;
    if (d <= `POC_DEG_90) r = d;
    else if (d <= `POC_DEG_180) begin
      r   = `POC_DEG_180 - d;
      neg = 1'b1;
    end else if (d <= `POC_DEG_270) begin
      r   = d - `POC_DEG_180;
      neg = 1'b1;
    end else r = `POC_DEG_360 - d;
    i = 4'(r / 10'd10);
    f = 4'(r % 10'd10);
    if (i == 4'h9) v = tab[9];
    else v = tab[i] - 13'((17'(tab[i] - tab[i + 4'h1]) * 17'(f)) / 17'd10);
    cos_q12 = neg ? -$signed({1'b0, v}) : $signed({1'b0, v});
  endfunction : cos_q12

  function automatic logic [1:0] argmax3(input logic [2:0][15:0] v);
    if (v[0] >= v[1] && v[0] >= v[2]) argmax3 = 2'd0;
    else if (v[1] >= v[2]) argmax3 = 2'd1;
    else argmax3 = 2'd2;
  endfunction : argmax3

  // Per-phase measurement conditioning
  logic [2:0][15:0] isat;
  logic [2:0][15:0] comp;
  logic [2:0][15:0] volt;
  logic [2:0]       vok;
  logic [2:0]       aok;

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_phase
      logic [9:0]         dsum;
      logic [9:0]         dif;
      logic signed [13:0] cv;
      assign isat[k] = (MEAS.cur[k] > `POC_I_MAX) ? `POC_I_MAX : MEAS.cur[k];
      assign volt[k] = MEAS.volt[k];
      // Too little voltage leaves the angle meaningless
      assign vok[k]  = 64'(MEAS.volt[k]) * `POC_SQRT3_Q10 * 64'd1000 >
                       64'(s.nom_volt) * `POC_MINV_PERMIL * 64'd1024;
      assign dsum    = 10'(MEAS.ang[k]) + `POC_DEG_360 - 10'(s.angle);
      assign dif     = (dsum >= `POC_DEG_360) ? dsum - `POC_DEG_360 : dsum;
      assign aok[k]  = (dif < `POC_DEG_90) || (dif > `POC_DEG_270);
      assign cv      = cos_q12(dif);
      assign comp[k] = (cv > 14'sd0) ?
                       16'((32'(isat[k]) * 32'(cv)) >> 12) : 16'h0000;
    end
  endgenerate

  logic [1:0]  imx;
  logic [15:0] imax;
  logic [15:0] cmax;
  logic [15:0] vmin;
  logic [15:0] q;
  logic        ge;
  assign imx  = argmax3(isat);
  assign imax = isat[imx];
  assign cmax = comp[argmax3(comp)];

  always_comb begin
    vmin = volt[0];
    if (volt[1] < vmin) vmin = volt[1];
    if (volt[2] < vmin) vmin = volt[2];
    ge = 1'b0;
    case (s.dir)
      DIR_SUP: q = (vok[imx] && aok[imx]) ? imax : 16'h0000;
      DIR_VEC: begin
        q  = vok[argmax3(comp)] ? cmax : 16'h0000;
        ge = 1'b1;
      end
      default: q = imax;
    endcase
  end

  // Effective pickup as the ratio num/den, kept as products to avoid a divider
  logic [63:0] vs;
  logic [63:0] uq;
  logic [63:0] num;
  logic [63:0] den;
  logic [63:0] lhs;
  logic [63:0] thr;
  logic [63:0] rlv;
  logic        above;
  logic        below;
  logic        dbl;
  assign vs  = 64'(vmin) * `POC_SQRT3_Q10;
  assign uq  = 64'(s.nom_volt) << 10;
  assign dbl = (s.db == DB_ON);

  always_comb begin
    if (!s.restr || vs * 64'd5 >= uq * 64'd4) begin
      num = 64'd1;
      den = 64'd1;
    end else if (vs * 64'd5 < uq) begin
      num = `POC_LOW_NUM * uq;
      den = `POC_MID_NUM * uq;
    end else begin
      num = vs * `POC_PICK_NUM - uq;
      den = `POC_MID_NUM * uq;
    end
  end

  assign lhs   = 64'(q) * den * `POC_PICK_NUM;
  assign thr   = (64'(s.pickup) * num * `POC_PICK_NUM) << dbl;
  assign rlv   = (64'(s.pickup) * num * `POC_RST_NUM) << dbl;
  assign above = ge ? (lhs >= thr) : (lhs > thr);
  assign below = lhs < rlv;

  logic setup;
  logic access;
  assign setup  = APB_REQ.psel && !APB_REQ.penable;
  assign access = APB_REQ.psel && APB_REQ.penable;

  always_comb begin
    next_s = s;
    next_s.bi_sync = {s.bi_sync[1:0], BLOCK_IN};
    if (s.bi_sync[2] == s.bi_sync[1]) next_s.bi = s.bi_sync[1];
    next_s.tick = 1'b0;
    if (s.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = 32'h00000000;
      next_s.tick     = 1'b1;
    end else next_s.tick_cnt = s.tick_cnt + 32'h00000001;

    // Read data is latched in the setup phase so the access phase needs no wait
    if (setup) begin
      case (APB_REQ.paddr)
        `POC_OFS_CTRL:   next_s.prdata = {21'h0, s.relay_sel, 2'h0, s.bi_rel, s.dbl_en,
                                          s.restr, s.dir, s.enable};
        `POC_OFS_PICKUP: next_s.prdata = 32'(s.pickup);
        `POC_OFS_ANGLE:  next_s.prdata = 32'(s.angle);
        `POC_OFS_TRIP:   next_s.prdata = 32'(s.trip_delay);
        `POC_OFS_BODLY:  next_s.prdata = 32'(s.bo_delay);
        `POC_OFS_DBLMAX: next_s.prdata = 32'(s.dbl_max);
        `POC_OFS_NOMV:   next_s.prdata = 32'(s.nom_volt);
        `POC_OFS_STATUS: next_s.prdata = {26'h0, s.expired, s.bi, dbl, s.bo, s.trip, s.inst};
        default:         next_s.prdata = 32'h00000000;
      endcase
    end
    if (access && APB_REQ.pwrite) begin
      case (APB_REQ.paddr)
        `POC_OFS_CTRL: begin
          next_s.enable    = APB_REQ.pwdata[0];
          case (APB_REQ.pwdata[2:1])
            2'h1:    next_s.dir = DIR_SUP;
            2'h2:    next_s.dir = DIR_VEC;
            default: next_s.dir = DIR_OFF;
          endcase
          next_s.restr     = APB_REQ.pwdata[3];
          next_s.dbl_en    = APB_REQ.pwdata[4];
          next_s.bi_rel    = APB_REQ.pwdata[5];
          next_s.relay_sel = APB_REQ.pwdata[10:8];
        end
        `POC_OFS_PICKUP: next_s.pickup = 13'(clamp(APB_REQ.pwdata, `POC_MIN_PICKUP,
                                                   `POC_MAX_PICKUP));
        `POC_OFS_ANGLE:  next_s.angle = 9'(clamp(APB_REQ.pwdata, 32'h0,
                                                 `POC_MAX_ANGLE));
        `POC_OFS_TRIP:   next_s.trip_delay = 14'(clamp(APB_REQ.pwdata, `POC_MIN_TIME,
                                                       `POC_MAX_TIME));
        `POC_OFS_BODLY:  next_s.bo_delay = 7'(clamp(APB_REQ.pwdata, `POC_MIN_BODLY,
                                                    `POC_MAX_BODLY));
        `POC_OFS_DBLMAX: next_s.dbl_max = 14'(clamp(APB_REQ.pwdata, `POC_MIN_TIME,
                                                    `POC_MAX_TIME));
        `POC_OFS_NOMV:   next_s.nom_volt = APB_REQ.pwdata[15:0];
        default: ;
      endcase
    end

    // Instantaneous element with hysteresis
    if (!s.enable) next_s.inst = 1'b0;
    else if (above) next_s.inst = 1'b1;
    else if (below) next_s.inst = 1'b0;

    // Start drop clears all delay timers
    if (!s.enable || !s.inst) begin
      next_s.trip_cnt = 14'h0000;
      next_s.expired  = 1'b0;
      next_s.post_cnt = 8'h00;
    end else if (s.tick) begin
      if (!s.expired) begin
        next_s.trip_cnt = s.trip_cnt + 14'h0001;
        if (s.trip_cnt + 14'h0001 >= s.trip_delay) next_s.expired = 1'b1;
      end else if (s.post_cnt != 8'hFF) next_s.post_cnt = s.post_cnt + 8'h01;
    end
    next_s.trip = s.enable && s.inst && s.expired &&
                  (!s.bi || (s.bi_rel && s.post_cnt >= {s.bo_delay, 1'b0}));
    next_s.bo   = s.enable && s.inst &&
                  !(s.expired && s.post_cnt >= 8'(s.bo_delay));

    // Inrush detector: a rise from zero past 1.5 rated within the window doubles pickup
    case (s.db)
      DB_ZERO: begin
        if (imax > `POC_I_ZERO) begin
          next_s.db       = DB_RISE;
          next_s.rise_cnt = 3'h0;
        end
      end
      DB_RISE: begin
        if (imax >= `POC_I_RISE) begin
          next_s.db      = DB_ON;
          next_s.dbl_cnt = 14'h0000;
        end else if (imax <= `POC_I_ZERO) next_s.db = DB_ZERO;
        else if (s.tick) begin
          next_s.rise_cnt = s.rise_cnt + 3'h1;
          if (32'(s.rise_cnt) + 32'd1 >= 32'(RISE_TICKS)) next_s.db = DB_WAIT;
        end
      end
      DB_ON: begin
        if (imax < `POC_I_HOLD) next_s.db = DB_WAIT;
        else if (s.tick) begin
          next_s.dbl_cnt = s.dbl_cnt + 14'h0001;
          if (s.dbl_cnt + 14'h0001 >= s.dbl_max) next_s.db = DB_WAIT;
        end
      end
      DB_WAIT: begin
        if (imax <= `POC_I_ZERO) next_s.db = DB_ZERO;
      end
      default: next_s.db = DB_ZERO;
    endcase
    if (!s.enable || !s.dbl_en) next_s.db = DB_ZERO;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s            <= '0;
      s.dir        <= DIR_OFF;
      s.pickup     <= `POC_RST_PICKUP;
      s.angle      <= `POC_RST_ANGLE;
      s.trip_delay <= `POC_RST_TRIP;
      s.bo_delay   <= `POC_RST_BODLY;
      s.dbl_max    <= `POC_RST_DBLMAX;
      s.nom_volt   <= `POC_RST_NOMV;
      s.db         <= DB_ZERO;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA     = s.prdata;
  assign PREADY     = 1'b1;
  assign PSLVERR    = access && !addr_ok(APB_REQ.paddr);
  assign INST_START = s.inst;
  assign TRIP       = s.trip;
  assign BLOCK_OUT  = s.bo;
  assign RELAY_OUT  = s.bo ? (8'h01 << s.relay_sel) : 8'h00;

endmodule : poc_top
`default_nettype wire

/* rtl/poc_consts.svh */
// Purpose: Constants of the phase overcurrent element
// Assumes: 200 MHz system clock, currents in units of 0.01 rated current
// Notes:   Register offsets are byte addresses on APB
`ifndef POC_CONSTS_SVH
`define POC_CONSTS_SVH

`define POC_OFS_CTRL       12'h000
`define POC_OFS_PICKUP     12'h004
`define POC_OFS_ANGLE      12'h008
`define POC_OFS_TRIP       12'h00C
`define POC_OFS_BODLY      12'h010
`define POC_OFS_DBLMAX     12'h014
`define POC_OFS_NOMV       12'h018
`define POC_OFS_STATUS     12'h01C

`define POC_RST_PICKUP     13'hFA0
`define POC_RST_ANGLE      9'h167
`define POC_RST_TRIP       14'h2710
`define POC_RST_BODLY      7'h4B
`define POC_RST_DBLMAX     14'h2710
`define POC_RST_NOMV       16'h0064

`define POC_MIN_PICKUP     32'h0000000A
`define POC_MAX_PICKUP     32'h00000FA0
`define POC_MAX_ANGLE      32'h00000167
`define POC_MIN_TIME       32'h00000002
`define POC_MAX_TIME       32'h00002710
`define POC_MIN_BODLY      32'h00000005
`define POC_MAX_BODLY      32'h0000004B

`define POC_TICK_MS        10
`define POC_CLK_KHZ        200000
`define POC_RISE_WIN_MS    60

`define POC_I_MAX          16'h0FA0
`define POC_I_RISE         16'h0096
`define POC_I_HOLD         16'h007D
`define POC_I_ZERO         16'h0002
`define POC_MINV_PERMIL    64'h000000000000000F
`define POC_SQRT3_Q10      64'h00000000000006EE
`define POC_RST_NUM        64'h0000000000000013
`define POC_PICK_NUM       64'h0000000000000014
`define POC_MID_NUM        64'h000000000000000F
`define POC_LOW_NUM        64'h0000000000000003
`define POC_DEG_90         10'h05A
`define POC_DEG_180        10'h0B4
`define POC_DEG_270        10'h10E
`define POC_DEG_360        10'h168

`endif

/* rtl/poc_pkg.sv */
// Purpose: Types of the phase overcurrent element
// Assumes: Constants come from poc_consts.svh
// Notes:   All module state is one packed struct
package poc_pkg;

  typedef enum logic [1:0] {DIR_OFF, DIR_SUP, DIR_VEC} poc_dir_type;
  typedef enum logic [1:0] {DB_ZERO, DB_RISE, DB_ON, DB_WAIT} poc_db_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } poc_apb_req_type;

  typedef struct packed {
    logic [2:0][15:0] cur;
    logic [2:0][8:0]  ang;
    logic [2:0][15:0] volt;
  } poc_meas_type;

  typedef struct packed {
    logic        enable;
    poc_dir_type dir;
    logic        restr;
    logic        dbl_en;
    logic        bi_rel;
    logic [2:0]  relay_sel;
    logic [12:0] pickup;
    logic [8:0]  angle;
    logic [13:0] trip_delay;
    logic [6:0]  bo_delay;
    logic [13:0] dbl_max;
    logic [15:0] nom_volt;
    logic [31:0] prdata;
    logic [2:0]  bi_sync;
    logic        bi;
    logic [31:0] tick_cnt;
    logic        tick;
    logic        inst;
    logic [13:0] trip_cnt;
    logic        expired;
    logic [7:0]  post_cnt;
    logic        trip;
    logic        bo;
    poc_db_type  db;
    logic [2:0]  rise_cnt;
    logic [13:0] dbl_cnt;
  } poc_state_type;

endpackage : poc_pkg

/* verification/poc_checker.sv */
// Purpose: Port-level assertions for the overcurrent element
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to poc_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module poc_checker (
  input wire logic                     CLK_SYS,
  input wire logic                     SYS_RST,
  input wire poc_pkg::poc_apb_req_type APB_REQ,
  input wire logic                     PSLVERR,
  input wire poc_pkg::poc_meas_type    MEAS,
  input wire logic                     INST_START,
  input wire logic                     TRIP,
  input wire logic                     BLOCK_OUT,
  input wire logic [7:0]               RELAY_OUT
);
  import poc_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  logic acc;
  assign acc = APB_REQ.psel && APB_REQ.penable;
  sequence s_start;
    $rose(INST_START);
  endsequence
  sequence s_no_trip2;
    !TRIP ##1 !TRIP;
  endsequence
  a_relay_onehot: assert property (BLOCK_OUT |-> $onehot(RELAY_OUT))
    else $error("relay output not one-hot");
  a_relay_idle: assert property (!BLOCK_OUT |-> RELAY_OUT == 8'h00)
    else $error("relay output active without blocking output");
  a_unmapped_err: assert property (acc && APB_REQ.paddr[11:5] != 7'h00 |-> PSLVERR)
    else $error("no error on unmapped access");
  // Unaligned offsets inside the map are unmapped too
  a_mapped_ok: assert property (acc && APB_REQ.paddr[11:5] == 7'h00 &&
                                APB_REQ.paddr[1:0] == 2'h0 |-> !PSLVERR)
    else $error("error on mapped access");
  a_bo_needs_inst: assert property (BLOCK_OUT |-> $past(INST_START))
    else $error("blocking output without instantaneous element");
  a_trip_needs_inst: assert property (TRIP |-> $past(INST_START))
    else $error("trip without pickup");
  a_start_no_trip: assert property (s_start |-> s_no_trip2)
    else $error("trip too soon after start");
  a_drop_clears: assert property ($fell(INST_START) |=> !TRIP && !BLOCK_OUT)
    else $error("outputs held after start dropped");
  a_zero_clears: assert property (MEAS.cur == '0 |=> !INST_START)
    else $error("element held with zero current");
  a_reset_quiet: assert property (disable iff (1'b0) SYS_RST |=> !TRIP && !BLOCK_OUT)
    else $error("outputs active after reset");
endmodule : poc_checker
bind poc_top poc_checker u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .APB_REQ(APB_REQ),
  .PSLVERR(PSLVERR), .MEAS(MEAS), .INST_START(INST_START), .TRIP(TRIP),
  .BLOCK_OUT(BLOCK_OUT), .RELAY_OUT(RELAY_OUT));
`default_nettype wire

/* verification/poc_far_end.sv */
// Purpose: Dry contact of external equipment on the blocking input
// Assumes: Bench commands closing and opening
// Notes:   Each change chatters for five clocks before settling
`timescale 1ns/1ps
`default_nettype none
module poc_far_end (
  input  wire logic clk,
  input  wire logic close_cmd,
  output var logic  contact
);
  logic [2:0] bounce;
  initial begin
    contact = 1'b0;
    bounce  = 3'h0;
  end
  // Real contacts chatter, so the input sync must ride it out
  always @(posedge clk) begin
    if (bounce != 3'h0) begin
      bounce  <= bounce - 3'h1;
      contact <= ~contact;
    end else if (contact != close_cmd) begin
      bounce <= 3'h5;
    end
  end
endmodule : poc_far_end
`default_nettype wire

/* verification/test_phase_overcurrent_element.sv */
// Purpose: Self-checking bench for the phase overcurrent element
// Assumes: Tick shortened to 20 clocks
// Notes:   Tick phase is free running, so windows timed from a start span one tick
`timescale 1ns/1ps
`default_nettype none
module test_phase_overcurrent_element;
  import poc_pkg::*;
  typedef struct packed {
    logic [3:0] ctrl; logic [7:0] v; logic [11:0] c; logic [8:0] a; logic e;
  } poc_case_type;
  localparam int TK = 20;
  localparam logic [31:0] RV[9] = '{32'h0, 32'hFA0, 32'h167, 32'h2710, 32'h4B,
                                    32'h2710, 32'h64, 32'h0, 32'h0};
  localparam poc_case_type CS[14] = '{
    '{4'h1,8'h64,12'h096,9'h0C8,1'b1}, '{4'h1,8'h64,12'h05A,9'h000,1'b0},
    '{4'h0,8'h64,12'h096,9'h000,1'b0}, '{4'h3,8'h64,12'h096,9'h050,1'b1},
    '{4'h3,8'h64,12'h096,9'h064,1'b0}, '{4'h3,8'h64,12'h096,9'h10E,1'b0},
    '{4'h3,8'h00,12'h096,9'h000,1'b0}, '{4'h5,8'h64,12'h190,9'h03C,1'b1},
    '{4'h5,8'h64,12'h190,9'h050,1'b0}, '{4'h5,8'h02,12'h190,9'h12C,1'b1},
    '{4'h9,8'h05,12'h03C,9'h000,1'b1}, '{4'h9,8'h64,12'h03C,9'h000,1'b0},
    '{4'h9,8'h28,12'h05A,9'h000,1'b1}, '{4'h9,8'h28,12'h050,9'h000,1'b0}};
  logic clk_sys, sys_rst, close_cmd, block_in, pready, pslverr, inst, trip, bo;
  poc_apb_req_type req;
  poc_meas_type    meas;
  logic [31:0]     prdata;
  logic [7:0]      relay;
  logic [31:0]     expq[$];
  int              n_fail, num_checks, n;
  logic [2:0]      r;
  poc_top #(.TICK_CYCLES(TK)) dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .APB_REQ(req),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MEAS(meas), .BLOCK_IN(block_in),
    .INST_START(inst), .TRIP(trip), .BLOCK_OUT(bo), .RELAY_OUT(relay));
  poc_far_end far (.clk(clk_sys), .close_cmd(close_cmd), .contact(block_in));
  always #2.5 clk_sys = ~clk_sys;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    req <= '0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wrrd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    apb(1'b1, a, d);
    rd(a, e);
  endtask : wrrd
  task automatic wt(input int c);
    repeat (c) @(negedge clk_sys);
  endtask : wt
  // Biggest current on a random phase, the others small so the maximum decides
  task automatic drive(input logic [15:0] c, input logic [8:0] a, input logic [15:0] v);
    logic [1:0] k;
    k = 2'($urandom % 3);
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      meas.cur[i]  <= (i == k) ? c : ((c >= 16'h0064) ? 16'($urandom % 32) : 16'h0000);
      meas.ang[i]  <= a;
      meas.volt[i] <= v;
    end
  endtask : drive
  task automatic bi(input logic lvl);
    @(posedge clk_sys);
    close_cmd <= lvl;
  endtask : bi
  // Read data is taken at the access edge, so the old request is still visible here
  always @(posedge clk_sys)
    if (req.psel && req.penable && pready === 1'b1 && !req.pwrite) check(prdata, expq.pop_front());
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    finish_test();
  end
  initial begin
    clk_sys = 1'b0; sys_rst = 1'b1; close_cmd = 1'b0; req = '0; meas = '0;
    void'($urandom(32'h40F4));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(12'(i * 4), RV[i]);
    wrrd(12'h004, 32'h1, 32'hA);
    wrrd(12'h004, 32'hFFFF, 32'hFA0);
    wrrd(12'h008, 32'h168, 32'h167);
    wrrd(12'h010, 32'h1, 32'h5);
    apb(1'b1, 12'h004, 32'h64);
    apb(1'b1, 12'h008, 32'h0);
    foreach (CS[i]) begin
      apb(1'b1, 12'h000, 32'(CS[i].ctrl));
      drive(16'(CS[i].c), CS[i].a, 16'(CS[i].v));
      wt(4);
      check(32'(inst), 32'(CS[i].e));
      drive(16'h0000, 9'h000, 16'h0064);
      wt(4);
    end
    r = 3'($urandom % 8);
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b1, 12'h010, 32'h5);
    apb(1'b1, 12'h000, {21'h0, r, 8'h01});
    drive(16'h00C8, 9'h000, 16'h0064);
    wt(3);
    check(32'(relay), 32'(8'h01 << r));
    n = 3;
    while (trip !== 1'b1 && n < 500) begin wt(1); n++; end
    check(32'(n >= 2 * TK && n <= 3 * TK + 6), 32'h1);
    n = 0;
    while (bo !== 1'b0 && n < 500) begin wt(1); n++; end
    check(32'(n >= 5 * TK - 6 && n <= 5 * TK + 6), 32'h1);
    drive(16'h0060, 9'h000, 16'h0064);
    wt(4);
    check({30'h0, inst, trip}, 32'h3);
    drive(16'h005E, 9'h000, 16'h0064);
    wt(4);
    check({30'h0, inst, trip}, 32'h0);
    bi(1'b1);
    wt(20);
    rd(12'h01C, 32'h10);
    drive(16'h00C8, 9'h000, 16'h0064);
    wt(18 * TK);
    check(32'(trip), 32'h0);
    drive(16'h0000, 9'h000, 16'h0064);
    apb(1'b1, 12'h000, {21'h0, r, 8'h21});
    drive(16'h00C8, 9'h000, 16'h0064);
    n = 0;
    while (trip !== 1'b1 && n < 800) begin wt(1); n++; end
    check(32'(n >= 12 * TK - 6 && n <= 13 * TK + 10), 32'h1);
    bi(1'b0);
    drive(16'h0000, 9'h000, 16'h0064);
    apb(1'b1, 12'h014, 32'hA);
    apb(1'b1, 12'h000, 32'h11);
    wt(25);
    drive(16'h00A0, 9'h000, 16'h0064);
    wt(10);
    check(32'(inst), 32'h0);
    rd(12'h01C, 32'h8);
    drive(16'h0078, 9'h000, 16'h0064);
    wt(6);
    check(32'(inst), 32'h1);
    drive(16'h0000, 9'h000, 16'h0064);
    wt(4);
    drive(16'h00A0, 9'h000, 16'h0064);
    wt(10);
    check(32'(inst), 32'h0);
    wt(12 * TK);
    check(32'(inst), 32'h1);
    finish_test();
  end
endmodule : test_phase_overcurrent_element
`default_nettype wire
